//--- hw/sbt_arbiter.sv
`default_nettype none
module sbt_arbiter #(
   parameter int FIFO_DEPTH = 4
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // core request side
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic [2:0] req_op_i,
   input wire logic req_burst_i,
   input wire logic [sbt_pkg::ADDR_W-1:0] req_addr_i,
   input wire logic [sbt_pkg::ATTR_W-1:0] req_attr_i,
   input wire logic address_broadcast_enable_i,
   // core write data side
   input wire logic wdata_valid_i,
   output logic wdata_ready_o,
   input wire logic [sbt_pkg::DATA_W-1:0] wdata_i,
   // core read data and completion
   output logic rdata_valid_o,
   output logic [sbt_pkg::DATA_W-1:0] rdata_o,
   output logic done_o,
   // address bus arbitration
   output logic addr_bus_request_n_o,
   input wire logic addr_bus_grant_n_i,
   input wire logic addr_busy_n_i,
   output logic addr_busy_n_o,
   output logic addr_busy_oe_o,
   input wire logic addr_retry_n_i,
   input wire logic addr_acknowledge_n_i,
   // address transfer
   output logic transfer_start_n_o,
   output logic [sbt_pkg::ADDR_W-1:0] addr_o,
   output logic [sbt_pkg::ATTR_W-1:0] attr_o,
   output logic addr_oe_o,
   // data bus arbitration
   input wire logic data_grant_n_i,
   input wire logic write_only_data_grant_n_i,
   input wire logic data_busy_n_i,
   output logic data_busy_n_o,
   output logic data_busy_oe_o,
   input wire logic data_retry_n_i,
   input wire logic data_ack_n_i,
   // data transfer
   input wire logic [sbt_pkg::DATA_W-1:0] data_i,
   output logic [sbt_pkg::DATA_W-1:0] data_o,
   output logic data_oe_o
);
   import sbt_pkg::*;

   // ==========================================
   // write data buffer
   logic wf_valid, wf_pop;
   logic [DATA_W-1:0] wf_data;

   sbt_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .in_valid_i(wdata_valid_i),
      .in_ready_o(wdata_ready_o),
      .in_data_i(wdata_i),
      .out_valid_o(wf_valid),
      .out_ready_i(wf_pop),
      .out_data_o(wf_data)
   );

   // ==========================================
   // address tenure state
   sbt_astate_type ast_ff, nxt_ast;
   logic [ADDR_W-1:0] addr_ff, nxt_addr;
   logic [ATTR_W-1:0] attr_ff, nxt_attr;
   logic ts_ff, nxt_ts, abb_ff, nxt_abb, br_ff, nxt_br;
   logic ahave_ff, nxt_ahave;          // request latched, awaiting bus
   logic aop_wr_ff, nxt_aop_wr, aop_bu_ff, nxt_aop_bu, aop_ao_ff, nxt_aop_ao;
   // data tenure queue: slot0 oldest, slot1 pipelined
   logic [1:0] qv_ff, nxt_qv, qwr_ff, nxt_qwr, qbu_ff, nxt_qbu;
   logic qsel;                          // slot chosen for the data tenure
   logic addr_only, a_qual, d_qual, d_need, a_done, a_retry, d_end;
   sbt_dstate_type dst_ff, nxt_dst;
   logic [2:0] beat_ff, nxt_beat;
   logic dbb_ff, nxt_dbb, doe_ff, nxt_doe, dwr_ff, nxt_dwr, dbu_ff, nxt_dbu;
   logic dslot_ff, nxt_dslot;
   logic [DATA_W-1:0] dout_ff, nxt_dout, rd_ff, nxt_rd;
   logic rdv_ff, nxt_rdv, done_ff, nxt_done;
   logic local_op, a_local;            // cache op kept off the bus
   logic [1:0] dpend_ff, nxt_dpend;    // completions waiting for their done pulse
   logic [2:0] dtotal;

   // address-only classification
   always_comb begin
      addr_only = (req_op_i == OP_ZERO) ||
                  (address_broadcast_enable_i &&
                   (req_op_i == OP_CACHE || req_op_i == OP_SYNC));
      // cache ops are not broadcast without the enable: no bus traffic at all
      local_op = !address_broadcast_enable_i &&
                 (req_op_i == OP_CACHE || req_op_i == OP_SYNC);
   end

   assign req_ready_o = !ahave_ff && (ast_ff == SBT_A_IDLE);

   // ==========================================
   // address tenure next state
   always_comb begin
      nxt_ast = ast_ff;
      nxt_addr = addr_ff;
      nxt_attr = attr_ff;
      nxt_ts = 1'b0;
      nxt_abb = abb_ff;
      nxt_br = br_ff;
      nxt_ahave = ahave_ff;
      nxt_aop_wr = aop_wr_ff;
      nxt_aop_bu = aop_bu_ff;
      nxt_aop_ao = aop_ao_ff;
      a_done = 1'b0;
      a_retry = 1'b0;
      a_local = 1'b0;
      // qualified grant, busy input or-ed with own busy
      a_qual = !addr_bus_grant_n_i && addr_busy_n_i && !abb_ff && addr_retry_n_i;
      case (ast_ff)
         SBT_A_IDLE: begin
            if (req_valid_i && req_ready_o && local_op) begin
               a_local = 1'b1;            // finished locally, only a done pulse
            end else if (req_valid_i && req_ready_o) begin
               nxt_ahave = 1'b1;
               nxt_addr = req_addr_i;
               nxt_attr = req_attr_i;
               nxt_aop_wr = (req_op_i == OP_WRITE);
               nxt_aop_bu = req_burst_i;
               nxt_aop_ao = addr_only;
            end
            // one own tenure beyond the current data tenure
            if (ahave_ff && !qv_ff[1]) begin
               if (a_qual) begin
                  nxt_ast = SBT_A_XFER;   // parked or granted
                  nxt_ts = 1'b1;
                  nxt_abb = 1'b1;
                  nxt_br = 1'b0;
               end else begin
                  nxt_br = 1'b1;
               end
            end
         end
         SBT_A_XFER: begin
            if (!addr_acknowledge_n_i) begin
               nxt_abb = 1'b0;
               nxt_ast = SBT_A_GAP;
               if (!addr_retry_n_i) begin
                  a_retry = 1'b1;         // repeat the tenure
               end else begin
                  a_done = 1'b1;
                  nxt_ahave = 1'b0;
               end
            end
         end
         SBT_A_GAP: begin
            nxt_ast = SBT_A_IDLE;         // one idle clock of busy
         end
         default: begin
            nxt_ast = SBT_A_IDLE;
            nxt_abb = 1'b0;
         end
      endcase
   end

   // ==========================================
   // data tenure selection and next state
   always_comb begin
      // write-only grant picks a pending write ahead of a read
      if (!write_only_data_grant_n_i && qv_ff[1] && qwr_ff[1] && !(qv_ff[0] && qwr_ff[0])) begin
         qsel = 1'b1;
      end else begin
         qsel = 1'b0;                     // strict order otherwise
      end
      d_need = qv_ff[qsel] && (qwr_ff[qsel] || write_only_data_grant_n_i ||
               !data_grant_n_i);
      // retry of the paired address tenure only
      d_qual = !data_grant_n_i && data_busy_n_i && !dbb_ff && data_retry_n_i &&
               !(ast_ff == SBT_A_XFER && !addr_retry_n_i && !qv_ff[0]);
      d_end = 1'b0;
      nxt_dst = dst_ff;
      nxt_beat = beat_ff;
      nxt_dbb = dbb_ff;
      nxt_doe = 1'b0;
      nxt_dwr = dwr_ff;
      nxt_dbu = dbu_ff;
      nxt_dslot = dslot_ff;
      nxt_dout = dout_ff;
      nxt_rd = rd_ff;
      nxt_rdv = 1'b0;
      wf_pop = 1'b0;
      case (dst_ff)
         SBT_D_IDLE: begin
            if (d_need && d_qual && (!qwr_ff[qsel] || wf_valid)) begin
               nxt_dst = SBT_D_BEAT;
               nxt_dbb = 1'b1;
               nxt_dwr = qwr_ff[qsel];
               nxt_dbu = qbu_ff[qsel];
               nxt_dslot = qsel;
               nxt_beat = BEAT_ONE;
               nxt_doe = qwr_ff[qsel];    // drive on writes
               nxt_dout = wf_data;
               wf_pop = qwr_ff[qsel];
            end
         end
         SBT_D_BEAT: begin
            nxt_doe = dwr_ff;
            if (!data_ack_n_i) begin
               if (!dwr_ff) begin
                  nxt_rd = data_i;        // sample on reads
                  nxt_rdv = 1'b1;
               end
               if (!dbu_ff || beat_ff == BEAT_LAST) begin
                  d_end = 1'b1;           // final termination ends tenure
                  nxt_dst = SBT_D_IDLE;
                  nxt_dbb = 1'b0;
                  nxt_doe = 1'b0;
               end else begin
                  nxt_beat = beat_ff + 3'h1; // four beats per line
                  nxt_dout = wf_data;
                  wf_pop = dwr_ff;
               end
            end
         end
         default: begin
            nxt_dst = SBT_D_IDLE;
            nxt_dbb = 1'b0;
         end
      endcase
      // completions may coincide: queue them so each gets its own done pulse
      dtotal = 3'(dpend_ff) + 3'(a_done && aop_ao_ff) + 3'(d_end) + 3'(a_local);
      nxt_done = (dtotal != 3'h0);
      nxt_dpend = 2'(dtotal - 3'(nxt_done));
      // queue: push on completed address tenure that is not address-only, pop on tenure end
      nxt_qv = qv_ff;
      nxt_qwr = qwr_ff;
      nxt_qbu = qbu_ff;
      if (d_end && dslot_ff == 1'b0) begin
         nxt_qv = {1'b0, qv_ff[1]};
         nxt_qwr = {1'b0, qwr_ff[1]};
         nxt_qbu = {1'b0, qbu_ff[1]};
      end else if (d_end) begin
         nxt_qv[1] = 1'b0;
      end
      if (a_done && !aop_ao_ff) begin
         if (!nxt_qv[0]) begin
            nxt_qv[0] = 1'b1;
            nxt_qwr[0] = aop_wr_ff;
            nxt_qbu[0] = aop_bu_ff;
         end else begin
            nxt_qv[1] = 1'b1;
            nxt_qwr[1] = aop_wr_ff;
            nxt_qbu[1] = aop_bu_ff;
         end
      end
   end

   // ==========================================
   // registers, all bus outputs negated in reset
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ast_ff <= SBT_A_IDLE;
         addr_ff <= '0;
         attr_ff <= '0;
         ts_ff <= 1'b0;
         abb_ff <= 1'b0;
         br_ff <= 1'b0;
         ahave_ff <= 1'b0;
         aop_wr_ff <= 1'b0;
         aop_bu_ff <= 1'b0;
         aop_ao_ff <= 1'b0;
         qv_ff <= '0;
         qwr_ff <= '0;
         qbu_ff <= '0;
         dst_ff <= SBT_D_IDLE;
         beat_ff <= BEAT_ONE;
         dbb_ff <= 1'b0;
         doe_ff <= 1'b0;
         dwr_ff <= 1'b0;
         dbu_ff <= 1'b0;
         dslot_ff <= 1'b0;
         dout_ff <= '0;
         rd_ff <= '0;
         rdv_ff <= 1'b0;
         done_ff <= 1'b0;
         dpend_ff <= '0;
      end else begin
         ast_ff <= nxt_ast;
         addr_ff <= nxt_addr;
         attr_ff <= nxt_attr;
         ts_ff <= nxt_ts;
         abb_ff <= nxt_abb;
         br_ff <= nxt_br;
         ahave_ff <= nxt_ahave;
         aop_wr_ff <= nxt_aop_wr;
         aop_bu_ff <= nxt_aop_bu;
         aop_ao_ff <= nxt_aop_ao;
         qv_ff <= nxt_qv;
         qwr_ff <= nxt_qwr;
         qbu_ff <= nxt_qbu;
         dst_ff <= nxt_dst;
         beat_ff <= nxt_beat;
         dbb_ff <= nxt_dbb;
         doe_ff <= nxt_doe;
         dwr_ff <= nxt_dwr;
         dbu_ff <= nxt_dbu;
         dslot_ff <= nxt_dslot;
         dout_ff <= nxt_dout;
         rd_ff <= nxt_rd;
         rdv_ff <= nxt_rdv;
         done_ff <= nxt_done;
         dpend_ff <= nxt_dpend;
      end
   end

   // ==========================================
   // pin drive, busy lines driven only while owned
   assign addr_bus_request_n_o = !br_ff;
   assign addr_busy_n_o = !abb_ff;
   assign addr_busy_oe_o = abb_ff;
   assign transfer_start_n_o = !ts_ff;
   assign addr_o = addr_ff;
   assign attr_o = attr_ff;
   assign addr_oe_o = abb_ff;
   assign data_busy_n_o = !dbb_ff;
   assign data_busy_oe_o = dbb_ff;
   assign data_o = dout_ff;
   assign data_oe_o = doe_ff;
   assign rdata_o = rd_ff;
   assign rdata_valid_o = rdv_ff;
   assign done_o = done_ff;
   // unused retry-path marker
   logic unused_retry;
   assign unused_retry = a_retry;
endmodule : sbt_arbiter
`default_nettype wire

//--- hw/sbt_pkg.sv
`default_nettype none
package sbt_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 64;           // at most 64 bits a beat
   localparam int BURST_BEATS = 4;       // 32-byte line
   localparam int ATTR_W = 8;
   localparam logic [2:0] BEAT_LAST = 3'h3;
   localparam logic [2:0] BEAT_ONE = 3'h0;
   // request kinds
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_WRITE = 3'h1;
   localparam logic [2:0] OP_ZERO = 3'h2;      // block zero: address only
   localparam logic [2:0] OP_CACHE = 3'h3;     // flush/store/invalidate
   localparam logic [2:0] OP_SYNC = 3'h4;      // sync and ordering barrier
   typedef enum logic [1:0] {
      SBT_A_IDLE = 2'b00,
      SBT_A_XFER = 2'b01,
      SBT_A_GAP = 2'b10
   } sbt_astate_type;
   typedef enum logic [1:0] {
      SBT_D_IDLE = 2'b00,
      SBT_D_BEAT = 2'b01
   } sbt_dstate_type;
endpackage : sbt_pkg
`default_nettype wire

//--- hw/sbt_fifo.sv
`default_nettype none
module sbt_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [PW:0] cnt_ff, nxt_cnt;
   logic push, pop;

   // ==========================================
   // pointers and count
   always_comb begin
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      nxt_wr = push ? PW'(wr_ff + 1'b1) : wr_ff;
      nxt_rd = pop ? PW'(rd_ff + 1'b1) : rd_ff;
      nxt_cnt = (PW+1)'(cnt_ff + (PW+1)'(push) - (PW+1)'(pop));
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

   // storage, no reset needed
   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data_i;
      end
   end

   assign in_ready_o = (cnt_ff != (PW+1)'(DEPTH));
   assign out_valid_o = (cnt_ff != '0);
   assign out_data_o = mem_ff[rd_ff];
endmodule : sbt_fifo
`default_nettype wire

//--- verification/sbt_arbiter_monitor.sv
`default_nettype none
module sbt_arbiter_monitor (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // address side
   input wire logic addr_bus_request_n_o,
   input wire logic addr_bus_grant_n_i,
   input wire logic addr_busy_n_i,
   input wire logic addr_retry_n_i,
   input wire logic addr_acknowledge_n_i,
   input wire logic addr_busy_n_o,
   input wire logic addr_busy_oe_o,
   input wire logic transfer_start_n_o,
   input wire logic addr_oe_o,
   // data side
   input wire logic data_grant_n_i,
   input wire logic data_busy_n_i,
   input wire logic data_retry_n_i,
   input wire logic data_ack_n_i,
   input wire logic data_busy_n_o,
   input wire logic data_busy_oe_o,
   input wire logic data_oe_o,
   input wire logic rdata_valid_o,
   input wire logic done_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========
   // own tenures begun and not yet done
   logic [2:0] open_ff;
   logic [2:0] nxt_open;
   always_comb begin
      // a retried start is not a tenure; local completions must not underflow
      nxt_open = open_ff + 3'(!transfer_start_n_o) -
                 3'(!addr_acknowledge_n_i && !addr_retry_n_i && addr_busy_oe_o);
      if (done_o && nxt_open != 3'h0) begin
         nxt_open = nxt_open - 3'h1;
      end
   end
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         open_ff <= 3'h0;
      end else begin
         open_ff <= nxt_open;
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   a_start_owns:
   assert property (!transfer_start_n_o |-> !addr_busy_n_o && addr_busy_oe_o && addr_oe_o)
      else $error("start without address ownership");
   a_start_qualified:
   assert property ($fell(transfer_start_n_o)
      |-> $past(!addr_bus_grant_n_i && addr_busy_n_i && addr_retry_n_i))
      else $error("start without qualified grant");
   a_start_pulse:
   assert property (!transfer_start_n_o |=> transfer_start_n_o)
      else $error("start longer than one cycle");
   a_start_drops_request:
   assert property (!transfer_start_n_o |-> addr_bus_request_n_o)
      else $error("request still low at start");
   a_busy_release:
   assert property (!addr_acknowledge_n_i && addr_busy_oe_o && !addr_busy_n_o
      |=> ##[0:1] !(addr_busy_oe_o && !addr_busy_n_o))
      else $error("address busy held after acknowledge");
   a_busy_gap:
   assert property ($rose(addr_busy_n_o) |=> addr_busy_n_o)
      else $error("address busy reasserted without a gap");
   a_addr_owned:
   assert property (addr_oe_o |-> addr_busy_oe_o && !addr_busy_n_o)
      else $error("address driven without ownership");
   a_data_qualified:
   assert property ($rose(data_busy_oe_o)
      |-> !data_busy_n_o && $past(!data_grant_n_i && data_busy_n_i && data_retry_n_i))
      else $error("data bus taken without qualified grant");
   a_data_owned:
   assert property (data_oe_o |-> data_busy_oe_o && !data_busy_n_o)
      else $error("data driven without ownership");
   a_read_beat:
   assert property (rdata_valid_o
      |-> $past(!data_ack_n_i && data_busy_oe_o && !data_busy_n_o && !data_oe_o))
      else $error("read data without read beat");
   a_pipe_depth:
   assert property (open_ff <= 3'h2)
      else $error("more than two own tenures open");
endmodule : sbt_arbiter_monitor

bind sbt_arbiter sbt_arbiter_monitor sbt_arbiter_monitor_inst (
   .ref_clk_i, .rstn_i, .addr_bus_request_n_o, .addr_bus_grant_n_i, .addr_busy_n_i,
   .addr_retry_n_i, .addr_acknowledge_n_i, .addr_busy_n_o, .addr_busy_oe_o,
   .transfer_start_n_o, .addr_oe_o, .data_grant_n_i, .data_busy_n_i, .data_retry_n_i,
   .data_ack_n_i, .data_busy_n_o, .data_busy_oe_o, .data_oe_o, .rdata_valid_o, .done_o
);
`default_nettype wire

//--- verification/sbt_bus_model.sv
`default_nettype none
module sbt_bus_model (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // pacing from bench
   input wire logic slow_i,
   input wire logic [3:0] rnd_i,
   // seen from the device
   input wire logic request_n_i,
   input wire logic start_n_i,
   input wire logic dbusy_n_i,
   input wire logic doe_i,
   // arbiter and slave answers
   output logic grant_n_o,
   output logic ack_n_o,
   output logic dgrant_n_o,
   output logic dack_n_o,
   output logic addr_retry_n_o,
   output logic data_retry_n_o,
   output logic wo_grant_n_o,
   output logic [63:0] data_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========
   // arbiter and slave, all on the rising edge
   logic pend;
   logic [1:0] delay;
   logic [31:0] seq;
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         grant_n_o <= 1'b1;
         ack_n_o <= 1'b1;
         dgrant_n_o <= 1'b1;
         dack_n_o <= 1'b1;
         addr_retry_n_o <= 1'b1;
         data_retry_n_o <= 1'b1;
         wo_grant_n_o <= 1'b1;
         data_o <= 64'h0;
         pend <= 1'b0;
         delay <= 2'h0;
         seq <= 32'h0;
      end else begin
         // grant on request, sometimes parked unasked
         grant_n_o <= !((!request_n_i && !(slow_i && rnd_i[0])) || rnd_i[1]);
         // data grant independent of address tenures
         dgrant_n_o <= slow_i && rnd_i[2];
         // write-only grant only rides on a data grant, so a lone read is still served
         wo_grant_n_o <= !(slow_i && rnd_i[0] && !rnd_i[2]);
         data_retry_n_o <= !(slow_i && rnd_i[1] && rnd_i[3]);
         // retry sometimes comes with the acknowledge: the tenure is repeated
         addr_retry_n_o <= !(start_n_i && pend && delay == 2'h0 && slow_i &&
                             rnd_i[0] && rnd_i[1]);
         // acknowledge two clocks or more after start
         ack_n_o <= 1'b1;
         if (!start_n_i) begin
            pend <= 1'b1;
            delay <= slow_i ? rnd_i[3:2] : 2'h0;
         end else if (pend && delay == 2'h0) begin
            ack_n_o <= 1'b0;
            pend <= 1'b0;
         end else if (pend) begin
            delay <= delay - 2'h1;
         end
         // one termination per beat, never two in a row
         dack_n_o <= !(!dbusy_n_i && dack_n_o && !(slow_i && rnd_i[3]));
         data_o <= ~data_o;
         if (!dbusy_n_i && dack_n_o) begin
            data_o <= {32'h5a5a5a5a, seq};
         end
         if (!dack_n_o && !doe_i) begin
            seq <= seq + 32'h1;
         end
      end
   end
endmodule : sbt_bus_model
`default_nettype wire

//--- verification/tb_split_bus_tenure_arbitration.sv
`default_nettype none
module tb_split_bus_tenure_arbitration;
   timeunit 1ns;
   timeprecision 100ps;
   import sbt_pkg::*;
   // ==========
   // signals
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic req_valid_i, req_burst_i, address_broadcast_enable_i, wdata_valid_i, slow;
   logic [2:0] req_op_i;
   logic [ADDR_W-1:0] req_addr_i, addr_o;
   logic [ATTR_W-1:0] req_attr_i, attr_o;
   logic [DATA_W-1:0] wdata_i, rdata_o, data_o, data_i;
   logic req_ready_o, wdata_ready_o, rdata_valid_o, done_o, addr_bus_request_n_o;
   logic addr_busy_n_o, addr_busy_oe_o, transfer_start_n_o, addr_oe_o;
   logic data_busy_n_o, data_busy_oe_o, data_oe_o;
   logic addr_bus_grant_n_i, addr_acknowledge_n_i, data_grant_n_i, data_ack_n_i;
   logic addr_retry_n_i, data_retry_n_i, write_only_data_grant_n_i; // from the far side
   logic [3:0] rnd;
   wire logic addr_busy_n_i = addr_busy_oe_o ? addr_busy_n_o : 1'b1;
   wire logic data_busy_n_i = data_busy_oe_o ? data_busy_n_o : 1'b1;
   logic [63:0] exp_addr[$], exp_wr[$], exp_rd[$];
   int seed = 32'h21b0;
   int pace_seed = 32'h21b0;
   int bad_count, comparisons, n_req, dones, beats, exp_beats, cycles;
   logic [31:0] rd_seq;
   logic [63:0] seen_addr;
   assign seen_addr = {24'h0, attr_o, addr_o};
   logic [2:0] ops[7] = '{OP_READ, OP_READ, OP_WRITE, OP_WRITE, OP_ZERO, OP_CACHE, OP_SYNC};
   sbt_arbiter #(.FIFO_DEPTH(4)) sbt_arbiter_inst (.*);
   sbt_bus_model sbt_bus_model_inst (
      .ref_clk_i, .rstn_i, .slow_i(slow), .rnd_i(rnd),
      .request_n_i(addr_bus_request_n_o), .start_n_i(transfer_start_n_o),
      .dbusy_n_i(data_busy_n_i), .doe_i(data_oe_o), .grant_n_o(addr_bus_grant_n_i),
      .ack_n_o(addr_acknowledge_n_i), .dgrant_n_o(data_grant_n_i),
      .dack_n_o(data_ack_n_i), .addr_retry_n_o(addr_retry_n_i),
      .data_retry_n_o(data_retry_n_i), .wo_grant_n_o(write_only_data_grant_n_i),
      .data_o(data_i)
   );
   always #4 ref_clk_i = ~ref_clk_i;
   // pacing and hang limit
   always @(posedge ref_clk_i) begin
      rnd <= 4'($random(pace_seed));
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   function automatic logic [63:0] pop(ref logic [63:0] q[$]);
      return q.size() > 0 ? q.pop_front() : 'x;
   endfunction : pop
   function automatic logic [63:0] peek(ref logic [63:0] q[$]);
      return q.size() > 0 ? q[0] : 'x;
   endfunction : peek
   task automatic test_done();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : test_done
   // write words into the buffer
   task automatic load(input int cnt);
      int n;
      logic [63:0] w;
      repeat (cnt) begin
         w = {$random(seed), $random(seed)};
         exp_wr.push_back(w);
         @(posedge ref_clk_i);
         wdata_valid_i <= 1'b1;
         wdata_i <= w;
         n = 0;
         @(negedge ref_clk_i);
         while (!wdata_ready_o && n < 500) begin
            n++;
            @(negedge ref_clk_i);
         end
         @(posedge ref_clk_i);
         wdata_valid_i <= 1'b0;
      end
   endtask : load
   // one request with its expectations
   task automatic send(input logic [2:0] op, input logic burst, input logic bce);
      int n;
      logic [63:0] r;
      r = {$random(seed), $random(seed)};
      // cache ops without broadcast never reach the bus
      if (op <= OP_ZERO || bce) begin
         exp_addr.push_back({24'h0, r[39:0]});
      end
      if (op == OP_READ || op == OP_WRITE) begin
         exp_beats += burst ? BURST_BEATS : 1;
      end
      if (op == OP_READ) begin
         repeat (burst ? BURST_BEATS : 1) begin
            exp_rd.push_back({32'h5a5a5a5a, rd_seq});
            rd_seq++;
         end
      end
      @(posedge ref_clk_i);
      req_valid_i <= 1'b1;
      req_op_i <= op;
      req_burst_i <= burst;
      address_broadcast_enable_i <= bce;
      req_addr_i <= r[31:0];
      req_attr_i <= r[39:32];
      n = 0;
      @(negedge ref_clk_i);
      while (!req_ready_o && n < 500) begin
         n++;
         @(negedge ref_clk_i);
      end
      @(posedge ref_clk_i);
      req_valid_i <= 1'b0;
      n_req++;
   endtask : send
   // result watcher against the notes
   always @(posedge ref_clk_i) begin
      if (rstn_i) begin
         if (!transfer_start_n_o) chk("address", peek(exp_addr), seen_addr);
         // a retried tenure keeps its note for the repeated start
         if (!addr_acknowledge_n_i && addr_busy_oe_o && addr_retry_n_i) begin
            void'(pop(exp_addr));
         end
         if (!data_ack_n_i && data_oe_o) chk("write data", pop(exp_wr), data_o);
         if (rdata_valid_o) chk("read data", pop(exp_rd), rdata_o);
         if (!data_ack_n_i && data_busy_oe_o) beats++;
         if (done_o) dones++;
      end
   end
   // main sequence
   initial begin
      int k;
      {req_valid_i, req_burst_i, address_broadcast_enable_i, wdata_valid_i, slow} = '0;
      {req_op_i, req_addr_i, req_attr_i, wdata_i, rd_seq} = '0;
      repeat (6) @(posedge ref_clk_i);
      chk("reset outputs", 64'h24, {58'h0, addr_bus_request_n_o, addr_busy_oe_o,
         data_busy_oe_o, transfer_start_n_o, addr_oe_o, data_oe_o});
      rstn_i <= 1'b1;
      load(4);
      @(negedge ref_clk_i);
      chk("buffer ready when full", 64'h0, {63'h0, wdata_ready_o});
      send(OP_WRITE, 1'b1, 1'b0);
      for (int i = 0; i < 21; i++) begin
         k = i % 7;
         slow <= i > 10;
         if (k == 2 || k == 3) load(k == 3 ? 4 : 1);
         send(ops[k], k == 1 || k == 3, 1'($random(seed)));
      end
      k = 0;
      while (dones != n_req && k < 3000) begin
         k++;
         @(posedge ref_clk_i);
      end
      repeat (10) @(posedge ref_clk_i);
      chk("completions", 64'(n_req), 64'(dones));
      chk("data beats", 64'(exp_beats), 64'(beats));
      chk("notes left", 64'h0, 64'(exp_addr.size() + exp_wr.size() + exp_rd.size()));
      test_done();
   end
endmodule : tb_split_bus_tenure_arbitration
`default_nettype wire
